// ---- src/serial_status_map.vh ----
// Register offsets, field positions and constants of the serial port status block
`ifndef SERIAL_STATUS_MAP_VH
`define SERIAL_STATUS_MAP_VH

`define OFS_DATA_PORT      12'h008
`define OFS_PORT_STATUS    12'h00C
`define OFS_CLOCK_PRESCALE 12'h010
`define OFS_INT_MASK       12'h014
`define OFS_RAW_STATUS     12'h018
`define OFS_MASKED_STATUS  12'h01C
`define OFS_INT_CLEAR      12'h020
`define OFS_CONTROL        12'h024

`define ST_BUSY      4
`define ST_RX_FULL   3
`define ST_RX_NEMPTY 2
`define ST_TX_NFULL  1
`define ST_TX_EMPTY  0

`define IRQ_TX_LEVEL   3
`define IRQ_RX_LEVEL   2
`define IRQ_RX_TIMEOUT 1
`define IRQ_RX_OVERRUN 0

`define CTL_ENABLE 0

`define QUEUE_DEPTH  8
`define QUEUE_HALF   4'h4
`define QUEUE_FULL   4'h8
`define LEVEL_W      4
`define DATA_W       16
`define PRESCALE_RST 8'h00
`define MASK_RST     4'h0
`define ZERO32       32'h00000000

`endif

// ---- src/word_queue.v ----
// Sixteen-bit queue of eight entries with push, pop and a fill level
`timescale 1ns/10ps
`default_nettype none
`include "serial_status_map.vh"
module word_queue (
  input  wire                clk,    // System clock
  input  wire                rst,    // Asynchronous reset, high
  input  wire                push,   // Write one entry
  input  wire [`DATA_W-1:0]  din,    // Entry to write
  input  wire                pop,    // Remove head entry
  output wire [`DATA_W-1:0]  dout,   // Head entry
  output reg  [`LEVEL_W-1:0] level   // Entries held
);
  reg  [`DATA_W-1:0] mem [0:`QUEUE_DEPTH-1];
  reg  [2:0]         wr_ptr;
  reg  [2:0]         rd_ptr;
  wire               do_push;
  wire               do_pop;

  assign do_pop  = pop && (level != 4'h0);
  assign do_push = push && ((level != `QUEUE_FULL) || do_pop);
  assign dout    = mem[rd_ptr];

  always @(posedge clk)
  begin
    if (do_push)
      mem[wr_ptr] <= din;
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr <= 3'h0;
      rd_ptr <= 3'h0;
      level  <= 4'h0;
    end
    else
    begin
      if (do_push)
        wr_ptr <= wr_ptr + 3'h1;
      if (do_pop)
        rd_ptr <= rd_ptr + 3'h1;
      if (do_push && !do_pop)
        level <= level + 4'h1;
      else if (do_pop && !do_push)
        level <= level - 4'h1;
    end
  end
endmodule
`default_nettype wire

// ---- src/prescale_divider.v ----
// Even divider producing the one-cycle port clock tick from the system clock
`timescale 1ns/10ps
`default_nettype none
`include "serial_status_map.vh"
module prescale_divider (
  input  wire       clk,      // System clock
  input  wire       rst,      // Asynchronous reset, high
  input  wire       run,      // Divider running
  input  wire [7:0] divisor,  // Even divisor, two or more
  output reg        tick,     // One pulse every divisor cycles
  output reg        level     // Divided clock, half period high
);
  reg [7:0] count;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      count <= 8'h00;
      tick  <= 1'b0;
      level <= 1'b0;
    end
    else if (!run || divisor < 8'h02)
    begin
      count <= 8'h00;
      tick  <= 1'b0;
      level <= 1'b0;
    end
    else if (count >= divisor - 8'h01)
    begin
      count <= 8'h00;
      tick  <= 1'b1;
      level <= 1'b1;
    end
    else
    begin
      count <= count + 8'h01;
      tick  <= 1'b0;
      if (count == {1'b0, divisor[7:1]} - 8'h01)
        level <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- src/serial_status_block.v ----
// Status flags, prescaler and interrupt sources of a synchronous serial port
// Overview of operation
// [R1] Busy while shifting or transmit queue holds data
// [R2] Status bit 3: receive queue full
// [R3] Status bit 2: receive queue not empty
// [R4] Status bit 1: transmit queue not full
// [R5] Status bit 0: transmit queue empty
// [R6] Software programs even divisor two to 254
// [R7] Divisor bit zero always held at zero
// [R8] System clock divided by programmed divisor
// [R9] Mask readable, one enables, resets zero
// [R10] Mask bits: tx 3, rx 2, timeout 1, overrun 0
// [R11] Raw bit 3: transmit queue half or less
// [R12] Raw bit 2: receive queue half or more
// [R13] Raw bit 1: timeout sticky until cleared
// [R14] Raw bit 0: overrun sticky until cleared
// [R15] Raw status read-only, unmasked values
// [R16] Masked status is raw AND mask
// [R17] Clear register: bit 1 timeout, bit 0 overrun
// [R18] Data read pops receive, write pushes transmit
// [R19] Disable port before reprogramming control registers
// [R20] Level sources follow occupancy, no clear bit
// [R21] Interrupt output ORs the masked bits
//
// The APB register port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "serial_status_map.vh"
module serial_status_block (
  input  wire               CLOCK,          // System clock, 250 MHz
  input  wire               SYS_RST,        // Asynchronous reset, high
  input  wire               PSEL,           // APB select
  input  wire               PENABLE,        // APB access phase
  input  wire               PWRITE,         // APB direction, high write
  input  wire [11:0]        PADDR,          // APB byte address
  input  wire [31:0]        PWDATA,         // APB write data
  output reg  [31:0]        PRDATA,         // APB read data
  output reg                PREADY,         // APB ready
  output reg                PSLVERR,        // APB error, unmapped
  input  wire               SHIFTER_ACTIVE, // Frame being shifted
  input  wire               TX_TAKE,        // Shifter takes tx entry
  output reg  [`DATA_W-1:0] TX_HEAD,        // Head of transmit queue
  output reg                TX_HEAD_VALID,  // Transmit queue not empty
  input  wire               RX_PUT,         // Shifter delivers rx entry
  input  wire [`DATA_W-1:0] RX_WORD,        // Received entry
  input  wire               RX_TIMEOUT,     // Receive time-out event
  output reg                PORT_ENABLE,    // Port enabled
  output reg                PORT_TICK,      // Divided clock tick
  output reg                PORT_CLOCK,     // Divided clock level
  output reg                INTERRUPT       // Combined interrupt
);
  reg  [7:0]          prescale_reg;
  reg  [3:0]          mask_reg;
  reg                 timeout_reg;
  reg                 overrun_reg;
  reg                 enable_reg;
  reg  [31:0]         rdata_next;
  reg                 err_next;
  wire [`LEVEL_W-1:0] tx_level;
  wire [`LEVEL_W-1:0] rx_level;
  wire [`DATA_W-1:0]  tx_dout;
  wire [`DATA_W-1:0]  rx_dout;
  wire                div_tick;
  wire                div_level;
  wire [3:0]          raw_status;
  wire [3:0]          masked_status;
  wire [4:0]          port_status;
  wire                setup;
  wire                wr_acc;
  wire                rd_acc;
  wire                tx_push;
  wire                rx_pop;
  wire                rx_overflow;
  wire                clr_timeout;
  wire                clr_overrun;

  // Address match against a register offset
  function hit;
    input [11:0] addr;
    input [11:0] ofs;
    begin
      hit = (addr[11:2] == ofs[11:2]);
    end
  endfunction

  // Transfer is taken in the setup cycle; answer comes in the access phase
  assign setup  = PSEL && !PENABLE;
  assign wr_acc = setup && PWRITE;
  assign rd_acc = setup && !PWRITE;

  assign tx_push = wr_acc && hit(PADDR, `OFS_DATA_PORT); // see [R18]
  assign rx_pop  = rd_acc && hit(PADDR, `OFS_DATA_PORT); // see [R18]

  word_queue tx_queue (
    .clk   (CLOCK),
    .rst   (SYS_RST),
    .push  (tx_push),
    .din   (PWDATA[`DATA_W-1:0]),
    .pop   (TX_TAKE),
    .dout  (tx_dout),
    .level (tx_level)
  );

  word_queue rx_queue (
    .clk   (CLOCK),
    .rst   (SYS_RST),
    .push  (RX_PUT),
    .din   (RX_WORD),
    .pop   (rx_pop),
    .dout  (rx_dout),
    .level (rx_level)
  );

  prescale_divider divider (
    .clk     (CLOCK),
    .rst     (SYS_RST),
    .run     (enable_reg),
    .divisor (prescale_reg),
    .tick    (div_tick),
    .level   (div_level)
  );

  // Overflow: entry arrives while the receive queue is full and not popped
  assign rx_overflow = RX_PUT && (rx_level == `QUEUE_FULL) && !rx_pop;

  assign port_status[`ST_BUSY]      = SHIFTER_ACTIVE ||
                                      (tx_level != 4'h0);  // see [R1]
  assign port_status[`ST_RX_FULL]   = (rx_level == `QUEUE_FULL); // see [R2]
  assign port_status[`ST_RX_NEMPTY] = (rx_level != 4'h0);  // see [R3]
  assign port_status[`ST_TX_NFULL]  = (tx_level != `QUEUE_FULL); // see [R4]
  assign port_status[`ST_TX_EMPTY]  = (tx_level == 4'h0);  // see [R5]

  assign raw_status[`IRQ_TX_LEVEL]   =
           (tx_level <= `QUEUE_HALF);     // see [R11] [R20]
  assign raw_status[`IRQ_RX_LEVEL]   =
           (rx_level >= `QUEUE_HALF);     // see [R12] [R20]
  assign raw_status[`IRQ_RX_TIMEOUT] = timeout_reg;  // see [R13]
  assign raw_status[`IRQ_RX_OVERRUN] = overrun_reg;  // see [R14]
  assign masked_status = raw_status & mask_reg;      // see [R16]

  assign clr_timeout = wr_acc && hit(PADDR, `OFS_INT_CLEAR) &&
                       PWDATA[`IRQ_RX_TIMEOUT];      // see [R17]
  assign clr_overrun = wr_acc && hit(PADDR, `OFS_INT_CLEAR) &&
                       PWDATA[`IRQ_RX_OVERRUN];      // see [R17]

  always @*
  begin
    rdata_next = `ZERO32;
    err_next   = 1'b0;
    if (hit(PADDR, `OFS_DATA_PORT))
      rdata_next[`DATA_W-1:0] = PWRITE ? 16'h0000 : rx_dout;
    else if (hit(PADDR, `OFS_PORT_STATUS))
      rdata_next[4:0] = port_status;
    else if (hit(PADDR, `OFS_CLOCK_PRESCALE))
      rdata_next[7:0] = prescale_reg;
    else if (hit(PADDR, `OFS_INT_MASK))
      rdata_next[3:0] = mask_reg;          // see [R9]
    else if (hit(PADDR, `OFS_RAW_STATUS))
      rdata_next[3:0] = raw_status;        // see [R15]
    else if (hit(PADDR, `OFS_MASKED_STATUS))
      rdata_next[3:0] = masked_status;     // see [R16]
    else if (hit(PADDR, `OFS_INT_CLEAR))
      rdata_next = `ZERO32;
    else if (hit(PADDR, `OFS_CONTROL))
      rdata_next[`CTL_ENABLE] = enable_reg;
    else
      err_next = 1'b1;
  end

  // APB answer: one wait-free access phase, data latched at setup
  always @(posedge CLOCK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      PRDATA  <= `ZERO32;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY  <= setup;
      PSLVERR <= setup && err_next;
      if (rd_acc)
        PRDATA <= rdata_next;
      else if (setup)
        PRDATA <= `ZERO32;
    end
  end

  // Writable registers; raw and masked status ignore writes
  always @(posedge CLOCK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      prescale_reg <= `PRESCALE_RST;
      mask_reg     <= `MASK_RST;
      enable_reg   <= 1'b0;
    end
    else if (wr_acc)
    begin
      if (hit(PADDR, `OFS_CLOCK_PRESCALE))
        prescale_reg <= {PWDATA[7:1], 1'b0};  // see [R7] [R8]
      if (hit(PADDR, `OFS_INT_MASK))
        mask_reg <= PWDATA[3:0];              // see [R9] [R10]
      if (hit(PADDR, `OFS_CONTROL))
        enable_reg <= PWDATA[`CTL_ENABLE];
    end
  end

  // Sticky sources: a new event in the clear cycle wins
  always @(posedge CLOCK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      timeout_reg <= 1'b0;
      overrun_reg <= 1'b0;
    end
    else
    begin
      if (RX_TIMEOUT)
        timeout_reg <= 1'b1;   // see [R13]
      else if (clr_timeout)
        timeout_reg <= 1'b0;   // see [R17]
      if (rx_overflow)
        overrun_reg <= 1'b1;   // see [R14]
      else if (clr_overrun)
        overrun_reg <= 1'b0;   // see [R17]
    end
  end

  // Registered outputs
  always @(posedge CLOCK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      INTERRUPT     <= 1'b0;
      PORT_ENABLE   <= 1'b0;
      PORT_TICK     <= 1'b0;
      PORT_CLOCK    <= 1'b0;
      TX_HEAD       <= 16'h0000;
      TX_HEAD_VALID <= 1'b0;
    end
    else
    begin
      INTERRUPT     <= |masked_status;   // see [R21]
      PORT_ENABLE   <= enable_reg;
      PORT_TICK     <= div_tick;         // see [R8]
      PORT_CLOCK    <= div_level;        // see [R8]
      TX_HEAD       <= tx_dout;
      TX_HEAD_VALID <= (tx_level != 4'h0) && !TX_TAKE;
    end
  end
endmodule
`default_nettype wire

// ---- dv/serial_status_monitor.sv ----
// Port-level assertions for the serial status block
`timescale 1ns/10ps
`default_nettype none
`include "serial_status_map.vh"
module serial_status_monitor (
  input wire logic        CLOCK,       // System clock
  input wire logic        SYS_RST,     // Reset, high
  input wire logic        PSEL,        // APB select
  input wire logic        PENABLE,     // APB access
  input wire logic        PWRITE,      // APB write
  input wire logic [11:0] PADDR,       // APB address
  input wire logic [31:0] PRDATA,      // APB read data
  input wire logic        PREADY,      // APB ready
  input wire logic        PSLVERR,     // APB error
  input wire logic        PORT_ENABLE, // Port enabled
  input wire logic        PORT_TICK,   // Divided tick
  input wire logic        INTERRUPT    // Combined interrupt
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  wire logic setup = PSEL && !PENABLE;
  wire logic rd = PREADY && !PWRITE && !PSLVERR;
  wire logic st = rd && PADDR == `OFS_PORT_STATUS;
  chk_ready_next: assert property (setup |=> PREADY)
    else $error("no ready after setup");
  chk_ready_cause: assert property (PREADY |-> $past(setup))
    else $error("ready without setup");
  chk_err_unmapped: assert property
    (setup && PADDR >= 12'h028 |=> PSLVERR) else $error("unmapped no error");
  chk_prescale_even: assert property
    (rd && PADDR == `OFS_CLOCK_PRESCALE
    |-> PRDATA[0] == 1'b0 && PRDATA[31:8] == 24'h0) else $error("odd divisor");
  chk_busy_txdata: assert property (st && !PRDATA[`ST_TX_EMPTY]
    |-> PRDATA[`ST_BUSY]) else $error("not busy with tx data");
  chk_full_nonempty: assert property (st && PRDATA[`ST_RX_FULL]
    |-> PRDATA[`ST_RX_NEMPTY]) else $error("full yet empty");
  chk_int_masked: assert property
    (rd && PADDR == `OFS_MASKED_STATUS
    |-> INTERRUPT == (|PRDATA[3:0])) else $error("interrupt differs");
  chk_tick_gap: assert property (PORT_TICK |=> !PORT_TICK)
    else $error("tick too long");
  chk_tick_off: assert property (!PORT_ENABLE [*3] |-> !PORT_TICK)
    else $error("tick while disabled");
  cover property (setup ##1 PSLVERR);
  cover property ($rose(INTERRUPT));
  cover property (PORT_TICK);
endmodule
bind serial_status_block serial_status_monitor i_mon (.CLOCK(CLOCK),
  .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .PORT_ENABLE(PORT_ENABLE), .PORT_TICK(PORT_TICK), .INTERRUPT(INTERRUPT));
`default_nettype wire

// ---- dv/serial_link_model.sv ----
// Behavioural shifter side feeding the serial status block
`timescale 1ns/10ps
`default_nettype none
module serial_link_model (
  input  wire logic        clk,     // System clock
  input  wire logic        put,     // Deliver a word
  input  wire logic        take,    // Take transmit head
  input  wire logic        tmo,     // Report time-out
  input  wire logic        act,     // Frame in shifter
  input  wire logic [15:0] word,    // Word to deliver
  output var  logic        rx_put,  // Word strobe
  output var  logic        tx_take, // Take strobe
  output var  logic        rx_tmo,  // Time-out strobe
  output var  logic        busy,    // Shifter active
  output var  logic [15:0] rx_word  // Delivered word
);
  initial {rx_put, tx_take, rx_tmo, busy, rx_word} = 20'h0;
  // Word line toggles outside strobes so stale data never looks valid
  always @(posedge clk)
  begin
    rx_put <= put;
    tx_take <= take;
    rx_tmo <= tmo;
    busy <= act;
    rx_word <= put ? word : ~rx_word;
  end
endmodule
`default_nettype wire

// ---- dv/sync_serial_status_irq_bench.sv ----
// Self-checking bench for the serial status block
`timescale 1ns/10ps
`default_nettype none
`include "serial_status_map.vh"
module sync_serial_status_irq_bench;
  logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, e;
  logic        act = 0, put = 0, take = 0, tmo = 0, rdy, err, irq, tick;
  logic        rput, ttake, rtmo, sact, hv, pe, pclk;
  logic [11:0] padr = 0;
  logic [31:0] pwd = 0, prd, r;
  logic [15:0] word = 0, head, rword, w, q [$];
  logic [7:0]  d;
  int          n_errors = 0, n_compared = 0, i, t;
  serial_status_block i_dut (.CLOCK(clk), .SYS_RST(rst), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd), .PRDATA(prd),
    .PREADY(rdy), .PSLVERR(err), .SHIFTER_ACTIVE(sact), .TX_TAKE(ttake),
    .TX_HEAD(head), .TX_HEAD_VALID(hv), .RX_PUT(rput), .RX_WORD(rword),
    .RX_TIMEOUT(rtmo), .PORT_ENABLE(pe), .PORT_TICK(tick), .PORT_CLOCK(pclk),
    .INTERRUPT(irq));
  serial_link_model i_link (.clk(clk), .put(put), .take(take), .tmo(tmo),
    .act(act), .word(word), .rx_put(rput), .tx_take(ttake), .rx_tmo(rtmo),
    .busy(sact), .rx_word(rword));
  initial
    forever #2 clk = ~clk;
  task automatic conclude;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] v);
    psel <= 1; pwr <= wr; padr <= a; pwd <= v;
    @(posedge clk) pen <= 1;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    r = prd; e = err;
    psel <= 0; pen <= 0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(0, a, 0);
    cmp(r, exp);
  endtask
  task automatic pulse(input int k);
    if (k == 0) put <= 1; else if (k == 1) take <= 1; else tmo <= 1;
    @(posedge clk) {put, take, tmo} <= 3'b0;
    repeat (3) @(posedge clk);
  endtask
  function automatic logic [31:0] stat(int tx, int rx, logic b);
    return {27'h0, b || tx > 0, rx == 8, rx > 0, tx < 8, tx == 0};
  endfunction
  initial
  begin
    #40000 n_errors++;
    conclude();
  end
  initial
  begin
    i = $urandom(32'hD46B9030);
    repeat (6) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    rd(`OFS_PORT_STATUS, 32'h3);
    rd(`OFS_CLOCK_PRESCALE, 32'h0);
    rd(`OFS_INT_MASK, 32'h0);
    rd(`OFS_RAW_STATUS, 32'h8);
    rd(`OFS_MASKED_STATUS, 32'h0);
    apb(1, `OFS_CONTROL, 0);
    for (i = 0; i < 4; i++)
    begin
      d = (i == 0) ? 8'hFF : 8'($urandom);
      apb(1, `OFS_CLOCK_PRESCALE, {24'h0, d});
      rd(`OFS_CLOCK_PRESCALE, {24'h0, d[7:1], 1'b0});
    end
    apb(1, `OFS_CLOCK_PRESCALE, 32'h4);
    apb(1, `OFS_CONTROL, 32'h1);
    cmp({31'h0, pe}, 32'h1);
    while (tick !== 1'b1) @(posedge clk);
    t = 0;
    do begin @(posedge clk); t++; end while (tick !== 1'b1);
    cmp(32'(t), 32'h4);
    cmp({31'h0, pclk}, 32'h1);
    apb(1, `OFS_CONTROL, 0);
    d = 8'($urandom);
    apb(1, `OFS_INT_MASK, {24'hFFFFFF, d});
    rd(`OFS_INT_MASK, {28'h0, d[3:0]});
    apb(1, `OFS_INT_MASK, 0);
    for (i = 1; i <= 9; i++)
    begin
      w = 16'($urandom);
      if (i < 9) q.push_back(w);
      apb(1, `OFS_DATA_PORT, {16'h0, w});
      rd(`OFS_PORT_STATUS, stat(q.size(), 0, 0));
      rd(`OFS_RAW_STATUS, {28'h0, q.size() <= 4, 3'b0});
    end
    while (q.size() > 0)
    begin
      cmp({31'h0, hv}, 32'h1);
      cmp({16'h0, head}, {16'h0, q.pop_front()});
      pulse(1);
    end
    cmp({31'h0, hv}, 32'h0);
    rd(`OFS_PORT_STATUS, 32'h3);
    act <= 1;
    @(posedge clk);
    rd(`OFS_PORT_STATUS, 32'h13);
    act <= 0;
    for (i = 1; i <= 9; i++)
    begin
      w = 16'($urandom);
      if (i < 9) q.push_back(w);
      word <= w;
      pulse(0);
      rd(`OFS_PORT_STATUS, stat(0, q.size(), 0));
      r = {28'h0, 1'b1, q.size() >= 4, 1'b0, i == 9};
      rd(`OFS_RAW_STATUS, r);
    end
    pulse(2);
    apb(1, `OFS_RAW_STATUS, 0);
    apb(1, `OFS_MASKED_STATUS, 0);
    rd(`OFS_RAW_STATUS, 32'hF);
    apb(1, `OFS_INT_MASK, 32'hF);
    rd(`OFS_MASKED_STATUS, 32'hF);
    cmp({31'h0, irq}, 32'h1);
    apb(1, `OFS_INT_CLEAR, 0);
    rd(`OFS_RAW_STATUS, 32'hF);
    apb(1, `OFS_INT_CLEAR, 32'h2);
    rd(`OFS_RAW_STATUS, 32'hD);
    apb(1, `OFS_INT_CLEAR, 32'h1);
    rd(`OFS_RAW_STATUS, 32'hC);
    while (q.size() > 0)
      rd(`OFS_DATA_PORT, {16'h0, q.pop_front()});
    rd(`OFS_RAW_STATUS, 32'h8);
    apb(1, `OFS_INT_MASK, 32'h7);
    rd(`OFS_MASKED_STATUS, 32'h0);
    cmp({31'h0, irq}, 32'h0);
    rd(12'h0FC, 32'h0);
    cmp({31'h0, e}, 32'h1);
    conclude();
  end
endmodule
`default_nettype wire
